/* ahl_pkg.sv */
// Shared constants, frame carrier and ASCII helpers for the host-link responder.
// Assumes a single 25 MHz clock and a byte-wide serial link with no parity.
package ahl_pkg;

    // Clock and serial timing
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_RATE = 38400;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int CNT_W = 16;
    localparam logic [3:0] RX_STOP_BIT = 4'(DATA_BITS + 1);
    localparam logic [3:0] TX_LAST_BIT = 4'(DATA_BITS + STOP_BITS);

    // Control characters
    localparam logic [7:0] CHR_ENQ = 8'h05;
    localparam logic [7:0] CHR_STAR = 8'h2A;
    localparam logic [7:0] CHR_CR = 8'h0D;

    // Command and error headers
    localparam logic [7:0] HDR_READ_IN0 = 8'h52;
    localparam logic [7:0] HDR_READ_IN1 = 8'h49;
    localparam logic [7:0] HDR_WRITE_OUT0 = 8'h57;
    localparam logic [7:0] HDR_WRITE_OUT1 = 8'h4F;
    localparam logic [7:0] HDR_ERR0 = 8'h45;
    localparam logic [7:0] HDR_ERR1 = 8'h52;

    // Payload sizes in hex characters, reply lengths in bytes
    localparam logic [2:0] HEX_READ = 3'h2;
    localparam logic [2:0] HEX_WRITE = 3'h4;
    localparam logic [2:0] HEX_MAX = 3'h4;
    localparam int REPLY_MAX = 6;
    localparam logic [2:0] LEN_READ = 3'h6;
    localparam logic [2:0] LEN_SHORT = 3'h4;

    // Buffer geometry
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;

    // Received command frame as collected
    typedef struct packed {
        logic [7:0] hdr0;
        logic [7:0] hdr1;
        logic [15:0] arg;
        logic [2:0] nhex;
        logic [1:0] nhdr;
        logic bad;
    } ahl_frame_t;

    // Nibble to upper-case ASCII hex digit
    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        hex_chr = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : hex_chr

    // ASCII hex digit to {valid, nibble}; either letter case accepted
    function automatic logic [4:0] hex_dec(input logic [7:0] c);
        hex_dec = 5'h00;
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_dec = {1'b1, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            hex_dec = {1'b1, c[3:0] + 4'h9};
        end
    endfunction : hex_dec

endpackage : ahl_pkg

/* ahl_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact, no word is overwritten.
`timescale 1ns/1ns
module ahl_fifo #(
    parameter int WIDTH = ahl_pkg::FIFO_WIDTH,
    parameter int DEPTH = ahl_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshakes; a full buffer holds the producer back
    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    // Storage has no reset; only the pointers and the count carry control state
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ahl_fifo

/* ahl_uart.sv */
// Byte serial transmitter and receiver, 8 data bits, 1 stop bit, no parity.
// Assumes the receive pin is asynchronous; it is synchronised here.
`timescale 1ns/1ns
module ahl_uart #(
    parameter int BIT_CYCLES = ahl_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Serial pins
    input wire logic rxd_in,
    output logic txd_out,
    // Transmit byte stream
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    // Received bytes
    output logic [7:0] rx_data_out,
    output logic rx_valid_out
);
    import ahl_pkg::*;

    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] BIT_HALF = CNT_W'(BIT_CYCLES / 2);

    logic rx_meta;
    logic rx_sync;
    logic rx_busy;
    logic [CNT_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic tx_busy;
    logic [CNT_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_shift;

    // Two-stage synchroniser on the receive pin
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rxd_in;
            rx_sync <= rx_meta;
        end
    end

    // Receiver samples mid-bit; a start glitch shorter than half a bit is dropped
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rx_busy <= 1'b0;
            rx_cnt <= '0;
            rx_bit <= 4'h0;
            rx_data_out <= 8'h00;
            rx_valid_out <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            if (!rx_busy) begin
                if (!rx_sync) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= BIT_HALF;
                    rx_bit <= 4'h0;
                end
            end else if (rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 1'b1;
            end else if (rx_bit == 4'h0) begin
                rx_busy <= !rx_sync;
                rx_bit <= 4'h1;
                rx_cnt <= BIT_LAST;
            end else if (rx_bit != RX_STOP_BIT) begin
                rx_data_out <= {rx_sync, rx_data_out[7:1]};
                rx_bit <= rx_bit + 1'b1;
                rx_cnt <= BIT_LAST;
            end else begin
                rx_busy <= 1'b0;
                rx_valid_out <= rx_sync;
            end
        end
    end

    // Transmitter: start bit, data LSB first, stop bit
    assign tx_ready_out = !tx_busy;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            tx_busy <= 1'b0;
            tx_cnt <= '0;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3FF;
        end else if (!tx_busy) begin
            if (tx_valid_in) begin
                tx_busy <= 1'b1;
                tx_shift <= {1'b1, tx_data_in, 1'b0};
                tx_cnt <= BIT_LAST;
                tx_bit <= 4'h0;
            end
        end else if (tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 1'b1;
        end else if (tx_bit == TX_LAST_BIT) begin
            tx_busy <= 1'b0;
        end else begin
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bit <= tx_bit + 1'b1;
            tx_cnt <= BIT_LAST;
        end
    end

    // Registered line driver keeps the pin glitch free; idle level is high
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            txd_out <= 1'b1;
        end else begin
            txd_out <= !tx_busy || tx_shift[0];
        end
    end
endmodule : ahl_uart

/* ahl_responder.sv */
// Point-to-point ASCII host-link responder: handshake, frame parse, reply.
// Assumes application inputs are on mclk_in; the serial pin is asynchronous.
// A refused command always gets the error header, a star and a carriage return.
//
// Overview of operation
// - The link runs at 38400 baud, 8 data bits, 1 stop bit, no parity on both ends.
// - A valid command is answered entirely by this logic with no application help.
// - A command frame starts with a two-character header naming the operation.
// - A frame ends with an asterisk followed by a carriage return (13).
// - Numeric payload travels as two hex characters per byte, 00 to FF.
// - The device echoes the Ctrl-E to show it is ready, and the host waits for it.
// - One reply frame follows each complete command and ends the session.
// - An accepted command is answered with its own header, any read data, then the terminator.
// - An unknown header or an illegal command gets an error reply instead.
// - Frames carry no controller address and are accepted without an address check.
`timescale 1ns/1ns
module ahl_responder #(
    parameter int IN_BYTES = 2,
    parameter int OUT_BYTES = 2,
    parameter int BIT_CYCLES = ahl_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Serial link
    input wire logic rxd_in,
    output logic txd_out,
    // Application data
    input wire logic [IN_BYTES*8-1:0] in_bits_in,
    output logic [OUT_BYTES*8-1:0] out_bits_out,
    // Status
    output logic session_out,
    output logic cmd_ok_out,
    output logic cmd_err_out
);
    import ahl_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_ECHO,
        ST_COLLECT,
        ST_STAR,
        ST_EXEC,
        ST_REPLY,
        ST_DRAIN
    } ahl_state_t;

    // Sequencer state and the frame as it is collected
    ahl_state_t state;
    ahl_frame_t frame;
    // Links to the serial engine and the reply buffer
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [7:0] push_data;
    logic push_valid;
    logic push_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    // Reply table, its length and the push position
    logic [7:0] reply [0:REPLY_MAX-1];
    logic [2:0] reply_len;
    logic [2:0] reply_idx;
    logic [2:0] push_idx;
    // Decode helpers
    logic [4:0] hex_in;
    logic [7:0] in_sel;
    logic is_read;
    logic is_write;
    logic read_ok;
    logic write_ok;

    // Serial engine, 8 data bits, 1 stop bit, no parity
    // Its receive flag lasts one clock per good byte
    ahl_uart #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_uart (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .rxd_in(rxd_in),
        .txd_out(txd_out),
        .tx_data_in(tx_data),
        .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready),
        .rx_data_out(rx_byte),
        .rx_valid_out(rx_valid)
    );

    // Reply bytes queue here so the sequencer never waits on each bit time
    // Eight words cover the longest reply with room to spare
    ahl_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .in_data_in(push_data),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .out_data_out(tx_data),
        .out_valid_out(tx_valid),
        .out_ready_in(tx_ready)
    );

    // Only the echo and the reply are ever pushed
    assign push_valid = (state == ST_ECHO) || (state == ST_REPLY);
    // After the last push of a read reply the index runs one past the table; keep the read inside it
    assign push_idx = (reply_idx < 3'(REPLY_MAX)) ? reply_idx : 3'h0;
    assign push_data = (state == ST_ECHO) ? CHR_ENQ : reply[push_idx];

    // Decode of the received character as a hex digit
    assign hex_in = hex_dec(rx_byte);

    // Input byte selected by the read index
    always_comb begin
        // An index past the inputs reads zero; such a read is refused anyway
        in_sel = 8'h00;
        for (int i = 0; i < IN_BYTES; i++) begin
            if (frame.arg[7:0] == 8'(i)) begin
                in_sel = in_bits_in[i*8 +: 8];
            end
        end
    end

    // Command classification; no address field is looked for
    assign is_read = (frame.hdr0 == HDR_READ_IN0) && (frame.hdr1 == HDR_READ_IN1);
    assign is_write = (frame.hdr0 == HDR_WRITE_OUT0) && (frame.hdr1 == HDR_WRITE_OUT1);
    // Out-of-range channels and wrong payload sizes count as illegal
    assign read_ok = is_read && !frame.bad && (frame.nhex == HEX_READ) &&
                     (frame.arg[7:0] < 8'(IN_BYTES));
    assign write_ok = is_write && !frame.bad && (frame.nhex == HEX_WRITE) &&
                      (frame.arg[15:8] < 8'(OUT_BYTES));

    // Session sequencer, fed one received byte at a time:
    //   idle    - wait for Ctrl-E, drop everything else
    //   echo    - queue the Ctrl-E echo and clear the frame store
    //   collect - header, then hex digits, up to a star
    //   star    - a carriage return closes the frame, another star keeps waiting
    //   exec    - judge the frame, fill the reply table, apply a write
    //   reply   - push the reply bytes into the buffer, one per clock
    //   drain   - wait for the last stop bit before going idle again
    // There is no frame timeout: a host that stops mid-frame leaves the session
    // open until reset, traded for a smaller sequencer.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Anything but Ctrl-E is dropped here
                    if (rx_valid && rx_byte == CHR_ENQ) begin
                        state <= ST_ECHO;
                    end
                end
                ST_ECHO: begin
                    // The buffer is empty between sessions, so this takes one clock
                    if (push_ready) begin
                        state <= ST_COLLECT;
                    end
                end
                ST_COLLECT: begin
                    // Other bytes go to the frame store below
                    if (rx_valid && rx_byte == CHR_STAR) begin
                        state <= ST_STAR;
                    end
                end
                ST_STAR: begin
                    // A second star keeps waiting for the carriage return
                    if (rx_valid) begin
                        if (rx_byte == CHR_CR) begin
                            state <= ST_EXEC;
                        end else if (rx_byte != CHR_STAR) begin
                            state <= ST_COLLECT;
                        end
                    end
                end
                ST_EXEC: begin
                    // One clock for the reply table and outputs to take the verdict
                    state <= ST_REPLY;
                end
                ST_REPLY: begin
                    // Leave once the last reply byte is in the buffer
                    if (push_ready && reply_idx == reply_len - 3'h1) begin
                        state <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    // Session closes only once the last stop bit has left
                    if (!tx_valid && tx_ready) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Frame collection; a stray star keeps the frame but marks it bad
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            frame <= '0;
        end else if (state == ST_ECHO) begin
            frame <= '0;
        end else if (rx_valid && state == ST_STAR && rx_byte != CHR_CR &&
                     rx_byte != CHR_STAR) begin
            frame.bad <= 1'b1;
        end else if (rx_valid && state == ST_COLLECT && rx_byte != CHR_STAR) begin
            // The first two characters are the header, whatever they are
            if (frame.nhdr == 2'h0) begin
                frame.hdr0 <= rx_byte;
                frame.nhdr <= 2'h1;
            end else if (frame.nhdr == 2'h1) begin
                frame.hdr1 <= rx_byte;
                frame.nhdr <= 2'h2;
            end else if (!hex_in[4] || frame.nhex == HEX_MAX) begin
                // A non-hex character or a fifth digit spoils the frame
                frame.bad <= 1'b1;
            end else begin
                frame.arg <= {frame.arg[11:0], hex_in[3:0]};
                frame.nhex <= frame.nhex + 3'h1;
            end
        end
    end

    // Reply assembly, done once per frame
    // Hex digits in a reply are always upper case; unused slots keep old bytes
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            for (int i = 0; i < REPLY_MAX; i++) begin
                reply[i] <= 8'h00;
            end
            reply_len <= LEN_SHORT;
        end else if (state == ST_EXEC) begin
            if (read_ok) begin
                reply[0] <= frame.hdr0;
                reply[1] <= frame.hdr1;
                reply[2] <= hex_chr(in_sel[7:4]);
                reply[3] <= hex_chr(in_sel[3:0]);
                reply[4] <= CHR_STAR;
                reply[5] <= CHR_CR;
                reply_len <= LEN_READ;
            end else if (write_ok) begin
                reply[0] <= frame.hdr0;
                reply[1] <= frame.hdr1;
                reply[2] <= CHR_STAR;
                reply[3] <= CHR_CR;
                reply_len <= LEN_SHORT;
            end else begin
                reply[0] <= HDR_ERR0;
                reply[1] <= HDR_ERR1;
                reply[2] <= CHR_STAR;
                reply[3] <= CHR_CR;
                reply_len <= LEN_SHORT;
            end
        end
    end

    // Reply byte index walks while the buffer accepts
    // It restarts at exec so a short reply after a long one starts at zero
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            reply_idx <= 3'h0;
        end else if (state == ST_EXEC) begin
            reply_idx <= 3'h0;
        end else if (state == ST_REPLY && push_ready) begin
            reply_idx <= reply_idx + 3'h1;
        end
    end

    // Output update happens at execution, before the reply goes out
    // Only the addressed byte changes; the others hold their value
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            out_bits_out <= '0;
        end else if (state == ST_EXEC && write_ok) begin
            for (int i = 0; i < OUT_BYTES; i++) begin
                if (frame.arg[15:8] == 8'(i)) begin
                    out_bits_out[i*8 +: 8] <= frame.arg[7:0];
                end
            end
        end
    end

    // Status flags for the application
    // Verdict pulses last one clock, in step with the output update
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            session_out <= 1'b0;
            cmd_ok_out <= 1'b0;
            cmd_err_out <= 1'b0;
        end else begin
            session_out <= (state != ST_IDLE);
            cmd_ok_out <= (state == ST_EXEC) && (read_ok || write_ok);
            cmd_err_out <= (state == ST_EXEC) && !(read_ok || write_ok);
        end
    end
endmodule : ahl_responder

/* ahl_responder_props.sv */
// Checker for the host-link responder: status pulses, line idle and bit timing.
// Assumes it is bound to ahl_responder and sees only that module's ports.
`timescale 1ns/1ns
module ahl_responder_props #(
    parameter int IN_BYTES = 2,
    parameter int OUT_BYTES = 2,
    parameter int BIT_CYCLES = 16
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Serial link
    input wire logic rxd_in,
    input wire logic txd_out,
    // Application data
    input wire logic [IN_BYTES*8-1:0] in_bits_in,
    input wire logic [OUT_BYTES*8-1:0] out_bits_out,
    // Status
    input wire logic session_out,
    input wire logic cmd_ok_out,
    input wire logic cmd_err_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);

    // Any low bit on the line lasts at least eight clocks (needs BIT_CYCLES >= 8)
    sequence s_low_bit;
        !txd_out [*8];
    endsequence
    // A verdict pulse is followed by eight quiet clocks, with no second verdict in them
    sequence s_quiet;
        (!cmd_ok_out && !cmd_err_out) [*8];
    endsequence

    AST_RESET_IDLE: assert property ($fell(srst_in) |-> txd_out && !session_out
        && !cmd_ok_out && !cmd_err_out && out_bits_out == '0)
        else $error("outputs not idle after reset");
    AST_ONE_VERDICT: assert property (!(cmd_ok_out && cmd_err_out))
        else $error("accept and error at once");
    AST_VERDICT_ONCE: assert property ((cmd_ok_out || cmd_err_out) |=> s_quiet)
        else $error("second verdict too soon");
    AST_VERDICT_IN_SESSION: assert property ((cmd_ok_out || cmd_err_out) |-> session_out)
        else $error("verdict outside a session");
    AST_IDLE_MARK: assert property (!session_out |-> txd_out)
        else $error("line driven while idle");
    AST_BIT_WIDTH: assert property ($fell(txd_out) |-> s_low_bit)
        else $error("low bit too short");
    AST_ECHO_PROMPT: assert property ($rose(session_out) |-> ##[0:12] !txd_out)
        else $error("echo did not start");
    AST_OUT_CAUSE: assert property (!$stable(out_bits_out) |-> cmd_ok_out || $past(cmd_ok_out))
        else $error("output bytes changed without a command");
endmodule : ahl_responder_props

bind ahl_responder ahl_responder_props #(.IN_BYTES(IN_BYTES), .OUT_BYTES(OUT_BYTES),
    .BIT_CYCLES(BIT_CYCLES)) i_props (.mclk_in(mclk_in), .srst_in(srst_in), .rxd_in(rxd_in),
    .txd_out(txd_out), .in_bits_in(in_bits_in), .out_bits_out(out_bits_out),
    .session_out(session_out), .cmd_ok_out(cmd_ok_out), .cmd_err_out(cmd_err_out));

/* ahl_host_model.sv */
// Host computer model: 8N1 serial sender and receiver on the far side of the link.
// Assumes BIT_CYCLES clocks per bit; the line idles high between bytes.
`timescale 1ns/1ns
module ahl_host_model #(
    parameter int BIT_CYCLES = 16
) (
    // Clock
    input wire logic mclk_in,
    // Serial lines
    input wire logic dev_txd_in,
    output logic host_txd_out
);
    logic [7:0] rx_q[$];
    logic [7:0] shift;

    // Mark level until the first byte
    initial begin
        host_txd_out = 1'b1;
    end

    // Start bit, eight data bits LSB first, one stop bit, no parity, no address
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frm;
        frm = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_in);
            host_txd_out <= frm[i];
            repeat (BIT_CYCLES - 1) @(posedge mclk_in);
        end
    endtask : send_byte

    // Mid-bit sampling; a byte whose stop bit is low is dropped as a real host would
    initial begin
        forever begin
            @(negedge dev_txd_in);
            repeat (BIT_CYCLES / 2) @(posedge mclk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge mclk_in);
                shift[i] = dev_txd_in;
            end
            repeat (BIT_CYCLES) @(posedge mclk_in);
            if (dev_txd_in === 1'b1) begin
                rx_q.push_back(shift);
            end
        end
    end
endmodule : ahl_host_model

/* tb_ahl_responder.sv */
// Testbench for the host-link responder: sessions, replies and refusals.
// Assumes the host model on the far side and a shortened bit time.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin logic [63:0] g_v; g_v = 64'(got); checks++; \
    if (g_v !== 64'(ex)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, g_v); end end
module tb_ahl_responder;
    import ahl_pkg::*;
    localparam int BITC = 16;
    logic mclk_in;
    logic srst_in;
    logic rxd;
    logic txd;
    logic [15:0] in_bits;
    logic [15:0] out_bits;
    logic session;
    logic cmd_ok;
    logic cmd_err;
    int bad_count;
    int checks;
    int ok_n;
    int err_n;

    ahl_responder #(.IN_BYTES(2), .OUT_BYTES(2), .BIT_CYCLES(BITC)) i_dut (
        .mclk_in(mclk_in), .srst_in(srst_in), .rxd_in(rxd), .txd_out(txd),
        .in_bits_in(in_bits), .out_bits_out(out_bits), .session_out(session),
        .cmd_ok_out(cmd_ok), .cmd_err_out(cmd_err));
    ahl_host_model #(.BIT_CYCLES(BITC)) i_host (
        .mclk_in(mclk_in), .dev_txd_in(txd), .host_txd_out(rxd));

    // 25 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // Count verdict pulses so each session can check it saw exactly one
    always @(posedge mclk_in) begin
        if (cmd_ok === 1'b1) ok_n++;
        if (cmd_err === 1'b1) err_n++;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // Bounded wait for n received bytes; a hang ends the run
    task automatic wait_rx(input int n);
        int t;
        t = 0;
        while (i_host.rx_q.size() < n && t < 4000) begin
            @(posedge mclk_in);
            t++;
        end
        if (t >= 4000) begin
            bad_count++;
            $display("[FAIL] reply bytes expected %0d seen %0d", n, i_host.rx_q.size());
            close_out();
        end
    endtask : wait_rx

    // Open with Ctrl-E, wait for the echo, send frame at once, check reply and verdict
    task automatic session_run(input string cmd, input string rep, input int ok_d, input int err_d);
        int ok0;
        int err0;
        ok0 = ok_n;
        err0 = err_n;
        i_host.send_byte(CHR_ENQ);
        wait_rx(1);
        `CHK("echo", CHR_ENQ, i_host.rx_q.pop_front())
        `CHK("session", 1'b1, session)
        for (int i = 0; i < cmd.len(); i++) i_host.send_byte(cmd[i]);
        i_host.send_byte(CHR_STAR);
        i_host.send_byte(CHR_CR);
        wait_rx(rep.len() + 2);
        for (int i = 0; i < rep.len(); i++) `CHK(cmd, rep[i], i_host.rx_q.pop_front())
        `CHK("star", CHR_STAR, i_host.rx_q.pop_front())
        `CHK("cr", CHR_CR, i_host.rx_q.pop_front())
        for (int t = 0; t < 4000 && session !== 1'b0; t++) @(posedge mclk_in);
        `CHK("end", 1'b0, session)
        if (session !== 1'b0) close_out();
        `CHK("ok", ok_d, ok_n - ok0)
        `CHK("err", err_d, err_n - err0)
    endtask : session_run

    // Without Ctrl-E the device stays silent and idle
    task automatic t_idle_junk();
        string s;
        s = "RI00*";
        `CHK("out reset", 16'h0000, out_bits)
        for (int i = 0; i < s.len(); i++) i_host.send_byte(s[i]);
        i_host.send_byte(CHR_CR);
        repeat (20 * BITC) @(posedge mclk_in);
        `CHK("silent", 0, i_host.rx_q.size())
        `CHK("idle", 1'b0, session)
        $display("test idle_junk done");
    endtask : t_idle_junk

    // Read both input bytes, each in its own session
    task automatic t_read();
        @(posedge mclk_in);
        in_bits <= 16'hA53C;
        session_run("RI01", "RIA5", 1, 0);
        session_run("RI00", "RI3C", 1, 0);
        session_run("RI00*", "RI3C", 1, 0);
        $display("test read done");
    endtask : t_read

    // Write output byte 1 with lower-case hex, then output byte 0 with upper-case hex
    task automatic t_write();
        session_run("WO017e", "WO", 1, 0);
        `CHK("out bits", 16'h7E00, out_bits)
        session_run("WO00FF", "WO", 1, 0);
        `CHK("out bits", 16'h7EFF, out_bits)
        $display("test write done");
    endtask : t_write

    // Unknown header, out-of-range channel, wrong digit count, bad character, stray star
    task automatic t_errors();
        string bad[6];
        bad = '{"ZZ", "RI02", "WO0212", "RI1", "RIG0", "RI0*1"};
        foreach (bad[i]) session_run(bad[i], "ER", 0, 1);
        `CHK("out kept", 16'h7EFF, out_bits)
        $display("test errors done");
    endtask : t_errors

    initial begin
        srst_in = 1'b1;
        in_bits = 16'h0000;
        bad_count = 0;
        checks = 0;
        ok_n = 0;
        err_n = 0;
        repeat (6) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        t_idle_junk();
        t_read();
        t_write();
        t_errors();
        close_out();
    end
endmodule : tb_ahl_responder
